// [rtl/mscb_map.vh]
`ifndef MSCB_MAP_VH
`define MSCB_MAP_VH

// Register indices on the configuration access port
`define MSCB_ADDR_W            12
`define MSCB_ADDR_STARTUP_SHD  12'h470
`define MSCB_ADDR_BRAKE_SHD    12'h471
`define MSCB_ADDR_STARTUP_NVM  12'h4d0
`define MSCB_ADDR_BRAKE_NVM    12'h4d1
`define MSCB_RESET_WORD        32'h0000_0000

// Startup/command word fields
`define MSCB_TAU_MSB           2
`define MSCB_TAU_LSB           0
`define MSCB_DIR_INV_BIT       3
`define MSCB_AVG_EN_BIT        4
`define MSCB_STAT_ADV_MSB      7
`define MSCB_STAT_ADV_LSB      5
`define MSCB_IDENT_EN_BIT      8
`define MSCB_IDENT_DUR_MSB     11
`define MSCB_IDENT_DUR_LSB     9
`define MSCB_IDENT_FREQ_MSB    17
`define MSCB_IDENT_FREQ_LSB    12
`define MSCB_WND_ADV_MSB       20
`define MSCB_WND_ADV_LSB       18
`define MSCB_ALIGN_MSB         22
`define MSCB_ALIGN_LSB         21
`define MSCB_PRECHG_BIT        23
`define MSCB_SHUNT_MSB         31
`define MSCB_SHUNT_LSB         24
`define MSCB_KE_FL_MSB         30
`define MSCB_KE_FL_LSB         28

// Brake policy word fields
`define MSCB_BRAKE_TYPE_BIT    0
`define MSCB_BRAKE_UNUSED_MASK 32'hffff_fffd
`define MSCB_BRAKE_REV_BIT     2
`define MSCB_BRAKE_WND_BIT     3
`define MSCB_BRAKE_OFF_BIT     4
`define MSCB_BRAKE_SEQ_MSB     7
`define MSCB_BRAKE_SEQ_LSB     5

// Scaling constants
`define MSCB_TAU_BASE          4'he
`define MSCB_ADV_STEP_EIGHTHS  9'h02d
`define MSCB_ALIGN_STEP_EIGHTHS 9'h087
`define MSCB_FREQ_BASE_CENTI   17'h0682e
`define MSCB_FREQ_STEP_CENTI   17'h00379
`define MSCB_KE_FL_BASE        4'h8

// Timing
`define MSCB_CLK_PERIOD_NS     4
`define MSCB_PRECHG_SHORT_NS   36000
`define MSCB_PRECHG_LONG_NS    72000
`define MSCB_IDENT_UNIT_MS     1125
`define MSCB_CLK_PER_MS        250000

`endif

// [rtl/mscb_sync.v]
`timescale 1ns/1ps
module mscb_sync (
  input  wire clock,
  input  wire reset,
  input  wire clockEnable,
  input  wire asyncIn,
  output reg  syncOut
);
  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clock) begin
    if (reset) begin
      stage1  <= 1'b0;
      stage2  <= 1'b0;
      stage3  <= 1'b0;
      syncOut <= 1'b0;
    end else if (clockEnable) begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      // Accept a change once two stages agree
      if (stage2 == stage3) begin
        syncOut <= stage3;
      end
    end
  end
endmodule

// [rtl/mscb_nvm.v]
`timescale 1ns/1ps
module mscb_nvm #(
  parameter WORDS  = 2,
  parameter DATA_W = 32
) (
  input  wire              clock,
  input  wire              reset,
  input  wire              clockEnable,
  input  wire              writeEnable,
  input  wire              address,
  input  wire [DATA_W-1:0] writeData,
  output reg  [DATA_W-1:0] readData
);
  reg [DATA_W-1:0] store [0:WORDS-1];
  integer          i;

  // Nonvolatile contents start blank and survive reset
  initial begin
    for (i = 0; i < WORDS; i = i + 1) begin
      store[i] = {DATA_W{1'b0}};
    end
  end

  always @(posedge clock) begin
    if (clockEnable && writeEnable) begin
      store[address] <= writeData;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      readData <= {DATA_W{1'b0}};
    end else if (clockEnable) begin
      readData <= store[address];
    end
  end
endmodule

// [rtl/mscb_config_bank.v]
// What this block does
// R01: Command low-pass, time constant 2^(14-N) samples; N zero bypasses filter.
// R02: Bit 3 of first word reverses commanded rotation direction.
// R03: Bit 4 enables averaging of the external command input.
// R04: Standstill start advance angle equals N times 5.625 degrees, bits 7:5.
// R05: Bit 8 enables speed-signal identification on speed-feedback output.
// R06: Identification sequence lasts (N+1) times 1.125 s, bits 11:9.
// R07: Identification frequency is 266.7 Hz plus N times 8.89 Hz, bits 17:12.
// R08: Windmill start advance angle equals N times 5.625 degrees, bits 20:18.
// R09: Align-start angle equals N times 16.875 degrees, bits 22:21.
// R10: Bootstrap precharge lasts 36 us when bit 23 clear, 72 us when set.
// R11: Single-shunt first-phase compensation equals twice bits 31:24.
// R12: Electrical constant fraction length equals 8 plus bits 30:28.
// R13: Second word bit 0: low-side braking when 0, constant current when 1.
// R14: Reverse rotation: decelerate when bit 2 clear, brake when set.
// R15: Second word bit 3 forces braking under windmill conditions.
// R16: Second word bit 4 brakes whenever the motor is commanded off.
// R17: Brake sequence length equals 2^(N+1) minus one, bits 7:5.
// R18: Second word bit 1 ignores writes and reads back zero.
`timescale 1ns/1ps
`include "mscb_map.vh"
module mscb_config_bank #(
  parameter CMD_W                = 16,
  parameter PRECHG_SHORT_CYCLES  = `MSCB_PRECHG_SHORT_NS / `MSCB_CLK_PERIOD_NS,
  parameter PRECHG_LONG_CYCLES   = `MSCB_PRECHG_LONG_NS / `MSCB_CLK_PERIOD_NS,
  parameter IDENT_UNIT_CYCLES    = `MSCB_IDENT_UNIT_MS * `MSCB_CLK_PER_MS
) (
  input  wire                    clock,
  input  wire                    reset,
  input  wire                    clockEnable,
  input  wire [`MSCB_ADDR_W-1:0] regAddress,
  input  wire                    regWrite,
  input  wire                    regRead,
  input  wire [31:0]             regWriteData,
  output reg  [31:0]             regReadData,
  output reg                     regReadValid,
  output reg                     loadDone,
  input  wire                    commandSample,
  input  wire [CMD_W-1:0]        commandIn,
  output reg  [CMD_W-1:0]        commandFiltered,
  input  wire                    directionPin,
  output reg                     directionOut,
  input  wire                    stationaryStart,
  output reg                     prechargeActive,
  input  wire                    identStart,
  output reg                     identActive,
  output reg  [16:0]             identFreqCentiHz,
  output reg  [8:0]              stationaryAdvanceEighths,
  output reg  [8:0]              windmillAdvanceEighths,
  output reg  [8:0]              alignAngleEighths,
  output reg  [8:0]              shuntCurrentComp,
  output reg  [3:0]              emfConstFracLen,
  input  wire                    motorReverse,
  input  wire                    motorWindmilling,
  input  wire                    motorCommandedOff,
  output reg                     brakeNow,
  output reg                     brakeConstantCurrent,
  output reg  [7:0]              brakeSequenceLen
);
  localparam ST_LOAD0 = 2'b00;
  localparam ST_LOAD1 = 2'b01;
  localparam ST_LOAD2 = 2'b10;
  localparam ST_RUN   = 2'b11;
  localparam FRAC_W   = `MSCB_TAU_BASE;
  localparam ACC_W    = CMD_W + FRAC_W;

  reg  [1:0]       state;
  reg  [31:0]      startupShadow;
  reg  [31:0]      brakeShadow;
  reg              readPending;
  reg              readFromNvm;
  reg  [31:0]      readHold;
  reg  [CMD_W-1:0] prevCommand;
  reg  [ACC_W-1:0] filterAcc;
  reg  [31:0]      prechargeCount;
  reg  [31:0]      identCount;
  wire             dirSynced;
  wire [31:0]      nvmReadData;
  wire             nvmSelect;
  wire             nvmWrite;
  wire             nvmAddress;
  wire [2:0]       tauField;
  wire [3:0]       tauShift;
  wire [CMD_W:0]   avgSum;
  wire [CMD_W-1:0] filterInput;
  wire signed [ACC_W+1:0] filterDiff;
  wire signed [ACC_W+1:0] filterStep;
  wire [31:0]      writeMasked;

  function [8:0] scaleEighths;
    input [2:0] n;
    input [8:0] step;
    begin
      scaleEighths = n * step;
    end
  endfunction

  function isAddr;
    input [`MSCB_ADDR_W-1:0] a;
    input [`MSCB_ADDR_W-1:0] b;
    begin
      isAddr = (a == b);
    end
  endfunction

  mscb_sync u_dirSync (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .asyncIn     (directionPin),
    .syncOut     (dirSynced)
  );

  assign nvmSelect  = isAddr(regAddress, `MSCB_ADDR_STARTUP_NVM) | isAddr(regAddress, `MSCB_ADDR_BRAKE_NVM);
  assign nvmWrite   = regWrite & nvmSelect & (state == ST_RUN);
  // Second word unused bit
  // R18: unused bit masked
  assign writeMasked = (isAddr(regAddress, `MSCB_ADDR_BRAKE_NVM) | isAddr(regAddress, `MSCB_ADDR_BRAKE_SHD))
                     ? (regWriteData & `MSCB_BRAKE_UNUSED_MASK) : regWriteData;
  assign nvmAddress = (state == ST_LOAD0) ? 1'b0 :
                      (state == ST_LOAD1) ? 1'b1 :
                      isAddr(regAddress, `MSCB_ADDR_BRAKE_NVM);

  mscb_nvm #(
    .WORDS  (2),
    .DATA_W (32)
  ) u_nvm (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .writeEnable (nvmWrite),
    .address     (nvmAddress),
    .writeData   (writeMasked),
    .readData    (nvmReadData)
  );

  // Shadow load after reset, then register access
  always @(posedge clock) begin
    if (reset) begin
      state         <= ST_LOAD0;
      startupShadow <= `MSCB_RESET_WORD;
      brakeShadow   <= `MSCB_RESET_WORD;
      loadDone      <= 1'b0;
      readPending   <= 1'b0;
      readFromNvm   <= 1'b0;
      readHold      <= 32'h0000_0000;
      regReadData   <= 32'h0000_0000;
      regReadValid  <= 1'b0;
    end else if (clockEnable) begin
      regReadValid <= 1'b0;
      readPending  <= 1'b0;
      case (state)
        ST_LOAD0: begin
          state <= ST_LOAD1;
        end
        ST_LOAD1: begin
          startupShadow <= nvmReadData;
          state         <= ST_LOAD2;
        end
        ST_LOAD2: begin
          brakeShadow <= nvmReadData & `MSCB_BRAKE_UNUSED_MASK;
          loadDone    <= 1'b1;
          state       <= ST_RUN;
        end
        ST_RUN: begin
          if (regWrite && isAddr(regAddress, `MSCB_ADDR_STARTUP_SHD)) begin
            startupShadow <= writeMasked;
          end
          if (regWrite && isAddr(regAddress, `MSCB_ADDR_BRAKE_SHD)) begin
            brakeShadow <= writeMasked;
          end
          if (regRead && !regWrite) begin
            readPending <= 1'b1;
            readFromNvm <= nvmSelect;
            if (isAddr(regAddress, `MSCB_ADDR_STARTUP_SHD)) begin
              readHold <= startupShadow;
            end else if (isAddr(regAddress, `MSCB_ADDR_BRAKE_SHD)) begin
              readHold <= brakeShadow;
            end else begin
              readHold <= 32'h0000_0000;
            end
          end
          if (readPending) begin
            regReadValid <= 1'b1;
            // R18: reads back zero
            regReadData  <= readFromNvm ? nvmReadData : readHold;
          end
        end
        default: begin
          state <= ST_LOAD0;
        end
      endcase
    end
  end

  assign tauField    = startupShadow[`MSCB_TAU_MSB:`MSCB_TAU_LSB];
  assign tauShift    = `MSCB_TAU_BASE - {1'b0, tauField};
  assign avgSum      = {1'b0, commandIn} + {1'b0, prevCommand};
  // R03: two-sample average
  assign filterInput = startupShadow[`MSCB_AVG_EN_BIT] ? avgSum[CMD_W:1] : commandIn;
  assign filterDiff  = $signed({2'b00, filterInput, {FRAC_W{1'b0}}}) - $signed({2'b00, filterAcc});
  assign filterStep  = filterDiff >>> tauShift;

  // Command conditioning
  always @(posedge clock) begin
    if (reset) begin
      prevCommand     <= {CMD_W{1'b0}};
      filterAcc       <= {ACC_W{1'b0}};
      commandFiltered <= {CMD_W{1'b0}};
    end else if (clockEnable) begin
      if (commandSample) begin
        prevCommand <= commandIn;
        // R01: filter or bypass
        if (tauField == 3'b000) begin
          filterAcc       <= {filterInput, {FRAC_W{1'b0}}};
          commandFiltered <= filterInput;
        end else begin
          filterAcc       <= filterAcc + filterStep[ACC_W-1:0];
          commandFiltered <= filterAcc[ACC_W-1:FRAC_W];
        end
      end
    end
  end

  // Timed sequences
  always @(posedge clock) begin
    if (reset) begin
      prechargeCount  <= 32'h0000_0000;
      prechargeActive <= 1'b0;
      identCount      <= 32'h0000_0000;
      identActive     <= 1'b0;
    end else if (clockEnable) begin
      // R10: precharge length select
      if (stationaryStart && !prechargeActive) begin
        prechargeActive <= 1'b1;
        prechargeCount  <= startupShadow[`MSCB_PRECHG_BIT] ? PRECHG_LONG_CYCLES - 1 : PRECHG_SHORT_CYCLES - 1;
      end else if (prechargeActive) begin
        if (prechargeCount == 32'h0000_0000) begin
          prechargeActive <= 1'b0;
        end else begin
          prechargeCount <= prechargeCount - 32'h0000_0001;
        end
      end
      // R05: ident enable gate
      // R06: ident duration
      if (identStart && !identActive && startupShadow[`MSCB_IDENT_EN_BIT]) begin
        identActive <= 1'b1;
        identCount  <= (startupShadow[`MSCB_IDENT_DUR_MSB:`MSCB_IDENT_DUR_LSB] + 32'h0000_0001)
                       * IDENT_UNIT_CYCLES - 32'h0000_0001;
      end else if (identActive) begin
        if (identCount == 32'h0000_0000 || !startupShadow[`MSCB_IDENT_EN_BIT]) begin
          identActive <= 1'b0;
        end else begin
          identCount <= identCount - 32'h0000_0001;
        end
      end
    end
  end

  // Decoded settings
  always @(posedge clock) begin
    if (reset) begin
      directionOut             <= 1'b0;
      identFreqCentiHz         <= `MSCB_FREQ_BASE_CENTI;
      stationaryAdvanceEighths <= 9'h000;
      windmillAdvanceEighths   <= 9'h000;
      alignAngleEighths        <= 9'h000;
      shuntCurrentComp         <= 9'h000;
      emfConstFracLen          <= `MSCB_KE_FL_BASE;
      brakeNow                 <= 1'b0;
      brakeConstantCurrent     <= 1'b0;
      brakeSequenceLen         <= 8'h01;
    end else if (clockEnable) begin
      // R02: direction inversion
      directionOut <= dirSynced ^ startupShadow[`MSCB_DIR_INV_BIT];
      // R07: ident frequency
      identFreqCentiHz <= `MSCB_FREQ_BASE_CENTI
                          + startupShadow[`MSCB_IDENT_FREQ_MSB:`MSCB_IDENT_FREQ_LSB] * `MSCB_FREQ_STEP_CENTI;
      // R04: standstill advance
      stationaryAdvanceEighths <= scaleEighths(startupShadow[`MSCB_STAT_ADV_MSB:`MSCB_STAT_ADV_LSB],
                                               `MSCB_ADV_STEP_EIGHTHS);
      // R08: windmill advance
      windmillAdvanceEighths <= scaleEighths(startupShadow[`MSCB_WND_ADV_MSB:`MSCB_WND_ADV_LSB],
                                             `MSCB_ADV_STEP_EIGHTHS);
      // R09: align angle
      alignAngleEighths <= scaleEighths({1'b0, startupShadow[`MSCB_ALIGN_MSB:`MSCB_ALIGN_LSB]},
                                        `MSCB_ALIGN_STEP_EIGHTHS);
      // R11: doubled compensation
      shuntCurrentComp <= {startupShadow[`MSCB_SHUNT_MSB:`MSCB_SHUNT_LSB], 1'b0};
      // R12: fraction length
      emfConstFracLen <= `MSCB_KE_FL_BASE + {1'b0, startupShadow[`MSCB_KE_FL_MSB:`MSCB_KE_FL_LSB]};
      // R14: reverse brake or decelerate
      // R15: windmill brakes only when bit 3 set
      // R16: brake when off
      brakeNow <= (motorReverse & brakeShadow[`MSCB_BRAKE_REV_BIT])
                | (motorWindmilling & brakeShadow[`MSCB_BRAKE_WND_BIT])
                | (motorCommandedOff & brakeShadow[`MSCB_BRAKE_OFF_BIT]);
      // R13: brake type
      brakeConstantCurrent <= brakeShadow[`MSCB_BRAKE_TYPE_BIT];
      // R17: sequence length
      brakeSequenceLen <= (8'h02 << brakeShadow[`MSCB_BRAKE_SEQ_MSB:`MSCB_BRAKE_SEQ_LSB]) - 8'h01;
    end
  end
endmodule

// [verification/mscb_config_bank_props.sv]
`timescale 1ns/1ps
module mscb_config_bank_props #(
  parameter PRECHG_SHORT_CYCLES = 9000,
  parameter PRECHG_LONG_CYCLES  = 18000
) (
  input wire        clock,
  input wire        reset,
  input wire        clockEnable,
  input wire [11:0] regAddress,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regWriteData,
  input wire        regReadValid,
  input wire        loadDone,
  input wire        prechargeActive,
  input wire        identStart,
  input wire        identActive,
  input wire [16:0] identFreqCentiHz,
  input wire [8:0]  stationaryAdvanceEighths,
  input wire [8:0]  shuntCurrentComp,
  input wire [3:0]  emfConstFracLen,
  input wire        motorReverse,
  input wire        motorWindmilling,
  input wire        motorCommandedOff,
  input wire        brakeNow,
  input wire        brakeConstantCurrent,
  input wire [7:0]  brakeSequenceLen
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire       wrOk = regWrite && loadDone && clockEnable;
  wire       w0   = wrOk && regAddress == 12'h470;
  wire       w1   = wrOk && regAddress == 12'h471;
  reg [15:0] pcLen;
  // Length of the current precharge pulse
  always @(posedge clock) begin
    if (reset)
      pcLen <= 16'h0;
    else if (clockEnable)
      pcLen <= prechargeActive ? pcLen + 16'h1 : 16'h0;
  end
  AST_READ: assert property (regRead && !regWrite && loadDone && clockEnable |-> ##2 regReadValid)
    else $error("read answer missing");
  AST_STAT_ADV: assert property (w0 |-> ##2 stationaryAdvanceEighths == $past(regWriteData[7:5], 2) * 9'd45)
    else $error("stationary advance wrong");
  AST_FREQ: assert property (w0 |-> ##2 identFreqCentiHz == 17'd26670 + $past(regWriteData[17:12], 2) * 17'd889)
    else $error("ident frequency wrong");
  AST_SHUNT: assert property (w0 |-> ##2 shuntCurrentComp == {$past(regWriteData[31:24], 2), 1'b0})
    else $error("shunt compensation wrong");
  AST_FRACLEN: assert property (w0 |-> ##2 emfConstFracLen == 4'h8 + $past(regWriteData[30:28], 2))
    else $error("fraction length wrong");
  AST_BRAKE_CC: assert property (w1 |-> ##2 brakeConstantCurrent == $past(regWriteData[0], 2))
    else $error("brake type wrong");
  AST_SEQ_LEN: assert property (w1 |-> ##2 brakeSequenceLen == (8'h02 << $past(regWriteData[7:5], 2)) - 8'h01)
    else $error("brake sequence length wrong");
  AST_NO_BRAKE: assert property (!(motorReverse || motorWindmilling || motorCommandedOff) |=> !brakeNow)
    else $error("brake without cause");
  AST_PRECHG: assert property ($fell(prechargeActive) |-> pcLen == PRECHG_SHORT_CYCLES || pcLen == PRECHG_LONG_CYCLES)
    else $error("precharge length wrong");
  AST_IDENT: assert property ($rose(identActive) |-> $past(identStart))
    else $error("ident started without request");
  cover property (w1);
  cover property ($fell(prechargeActive));
  cover property (brakeNow);
endmodule
bind mscb_config_bank mscb_config_bank_props #(
  .PRECHG_SHORT_CYCLES(PRECHG_SHORT_CYCLES),
  .PRECHG_LONG_CYCLES (PRECHG_LONG_CYCLES)
) props (.*);

// [verification/mscb_host_model.sv]
`timescale 1ns/1ps
module mscb_host_model (
  input  wire        clock,
  input  wire        regReadValid,
  input  wire [31:0] regReadData,
  output reg  [11:0] regAddress,
  output reg         regWrite,
  output reg         regRead,
  output reg  [31:0] regWriteData
);
  integer i;
  initial begin
    regAddress = 12'h000;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWriteData = 32'h0;
  end
  // Released lines show the inverse of the last value
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge clock);
      regAddress <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      regAddress <= ~a;
      regWriteData <= ~d;
    end
  endtask
  task rd(input [11:0] a, output [31:0] d);
    begin
      @(posedge clock);
      regAddress <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      regAddress <= ~a;
      d = {32{1'bx}};
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clock);
        if (regReadValid === 1'b1) begin
          d = regReadData;
          i = 9;
        end
      end
    end
  endtask
endmodule

// [verification/mscb_config_bank_tb.sv]
`timescale 1ns/1ps
module mscb_config_bank_tb;
  localparam IU = 20;
  reg         clock = 0;
  reg         reset = 1;
  reg         clockEnable = 1;
  reg         commandSample = 0;
  reg  [15:0] commandIn = 16'h0;
  reg         directionPin = 0;
  reg         stationaryStart = 0;
  reg         identStart = 0;
  reg         motorReverse = 0;
  reg         motorWindmilling = 0;
  reg         motorCommandedOff = 0;
  wire [11:0] regAddress;
  wire        regWrite, regRead, regReadValid, loadDone, directionOut, prechargeActive, identActive;
  wire        brakeNow, brakeConstantCurrent;
  wire [31:0] regWriteData, regReadData;
  wire [15:0] commandFiltered;
  wire [16:0] identFreqCentiHz;
  wire [8:0]  stationaryAdvanceEighths, windmillAdvanceEighths, alignAngleEighths, shuntCurrentComp;
  wire [3:0]  emfConstFracLen;
  wire [7:0]  brakeSequenceLen;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     i, k, n;
  reg  [31:0] v, d;
  mscb_config_bank #(.PRECHG_SHORT_CYCLES(9), .PRECHG_LONG_CYCLES(18), .IDENT_UNIT_CYCLES(IU)) dut (.*);
  mscb_host_model host (.*);
  initial forever #2 clock = ~clock;
  task check(input [8*8:1] what, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer c);
    begin
      repeat (c) @(posedge clock);
      #1;
    end
  endtask
  task do_reset;
    begin
      @(posedge clock) reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      for (i = 0; i < 10 && loadDone !== 1'b1; i = i + 1) @(posedge clock);
      check("loaded", 32'h1, loadDone);
    end
  endtask
  task t_reset;
    begin
      check("freq", 32'd26670, identFreqCentiHz);
      check("fraclen", 32'd8, emfConstFracLen);
      check("seqlen", 32'd1, brakeSequenceLen);
      for (k = 0; k < 5; k = k + 1) begin
        host.rd(k == 4 ? 12'h472 : 12'h470 + k[0] + (k[1] ? 12'h060 : 12'h0), d);
        check("rdreset", 32'h0, d);
      end
    end
  endtask
  task t_startup;
    for (k = 0; k < 2; k = k + 1) begin
      v = k ? 32'hffff_ffff : 32'h5a3c_96c3;
      host.wr(12'h470, v);
      tick(2);
      check("statadv", v[7:5] * 32'd45, stationaryAdvanceEighths);
      check("wndadv", v[20:18] * 32'd45, windmillAdvanceEighths);
      check("align", v[22:21] * 32'd135, alignAngleEighths);
      check("shunt", v[31:24] * 32'd2, shuntCurrentComp);
      check("fraclen", v[30:28] + 32'd8, emfConstFracLen);
      check("freq", v[17:12] * 32'd889 + 32'd26670, identFreqCentiHz);
      check("dir", directionPin ^ v[3], directionOut);
      @(posedge clock) directionPin <= ~directionPin;
      tick(6);
      check("dir", directionPin ^ v[3], directionOut);
      host.rd(12'h470, d);
      check("rd470", v, d);
    end
  endtask
  task t_brake;
    begin
      for (n = 0; n < 8; n = n + 1) begin
        v = {24'h0, n[2:0], 4'hf, n[0]};
        host.wr(12'h471, v);
        tick(2);
        check("seqlen", (32'd2 << n) - 32'd1, brakeSequenceLen);
        check("cc", v[0], brakeConstantCurrent);
        host.rd(12'h471, d);
        check("rd471", v & 32'hffff_fffd, d);
      end
      for (n = 0; n < 3; n = n + 1) begin
        host.wr(12'h471, 32'h4 << n);
        for (k = 0; k < 3; k = k + 1) begin
          @(posedge clock) {motorCommandedOff, motorWindmilling, motorReverse} <= 3'b001 << k;
          tick(2);
          check("brake", n == k, brakeNow);
        end
        @(posedge clock) {motorCommandedOff, motorWindmilling, motorReverse} <= 3'b000;
      end
    end
  endtask
  task smp(input [15:0] x);
    begin
      @(posedge clock);
      commandSample <= 1'b1;
      commandIn <= x;
      @(posedge clock) commandSample <= 1'b0;
      #1;
    end
  endtask
  task t_command;
    begin
      host.wr(12'h470, 32'h0);
      smp(16'h1234);
      check("cmd", 32'h1234, commandFiltered);
      host.wr(12'h470, 32'h10);
      smp(16'h0100);
      smp(16'h0300);
      check("avg", 32'h0200, commandFiltered);
      host.wr(12'h470, 32'h7);
      smp(16'h4200);
      check("filt0", 32'h0200, commandFiltered);
      smp(16'h4200);
      check("filt1", 32'h0280, commandFiltered);
    end
  endtask
  task t_timed(input sel, input [31:0] w, input integer exp);
    begin
      host.wr(12'h470, w);
      @(posedge clock) {identStart, stationaryStart} <= sel ? 2'b10 : 2'b01;
      @(posedge clock) {identStart, stationaryStart} <= 2'b00;
      k = 0;
      for (i = 0; i < 60; i = i + 1) begin
        @(posedge clock);
        if ((sel ? identActive : prechargeActive) === 1'b1) k = k + 1;
      end
      check("length", exp, k);
    end
  endtask
  task t_nvm;
    begin
      host.wr(12'h4d1, 32'h0000_00ab);
      host.rd(12'h471, d);
      check("shadow", 32'h10, d);
      host.rd(12'h4d1, d);
      check("nvm", 32'ha9, d);
      do_reset;
      host.rd(12'h471, d);
      check("reload", 32'ha9, d);
      check("seqlen", 32'd63, brakeSequenceLen);
      check("statadv", 32'h0, stationaryAdvanceEighths);
    end
  endtask
  task t_freeze;
    begin
      @(posedge clock) clockEnable <= 1'b0;
      host.wr(12'h470, 32'h0000_00e0);
      tick(3);
      check("frozen", 32'h0, stationaryAdvanceEighths);
      @(posedge clock) clockEnable <= 1'b1;
      host.rd(12'h470, d);
      check("cefreeze", 32'h0, d);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial begin
    do_reset;
    t_reset;
    t_startup;
    t_brake;
    t_command;
    t_timed(0, 32'h0, 9);
    t_timed(0, 32'h80_0000, 18);
    t_timed(1, 32'h200, 0);
    t_timed(1, 32'h300, 2 * IU);
    t_nvm;
    t_freeze;
    test_done;
  end
endmodule
